// ---- hw/vid_adc_monitor.sv ----
`timescale 1ns/10ps
// Summary of operation
// - Id register bits 4:0 show five pins
// - Bit 5 zero in supply mode, else pin
// - Bit 6 drives the id threshold select
// - Bit 7 selects pin function, readable
// - Supply mode: status bit 0 shows limit
// - Id mode: status bit 0 shows id change
// - Flag set on change within 11 us window
// - Id change alerts unless mask bit set
// - Average 16 conversions unless averaging off
// - Config bit 5 drives attenuator bypass
// - Config bit 6 gives single-channel mode
// - Fan-1 high byte 7:5 selects channel
// - Local temperature upper byte at 0x26
// - Ten-bit two's complement, low bits extended
// - Remote temperatures average 16 cycles
// - Extended register packs remote2, local, remote1
// - Reading extended register freezes temperatures
module vid_adc_monitor
  import vid_adc_pkg::*;
#(
  parameter int CONV_TICKS = CONV_CYCLES,
  parameter int ID_TICKS = ID_WINDOW_CYCLES
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_clk_en,
  input wire logic [4:0] i_voltage_id_pins,
  input wire logic i_shared_pin_level,
  input wire logic i_supply12_out_of_limit,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  output logic o_reg_rvalid,
  input wire logic i_conv_done,
  input wire logic [9:0] i_conv_value,
  output logic o_conv_start,
  output logic [2:0] o_conv_channel,
  output logic o_bypass_attenuators,
  output logic o_id_threshold_select,
  output logic o_smbalert_n
);

  // ****************************************************************
  // Helpers
  // ****************************************************************

  // Round robin over voltages then temperatures; the 12 V slot is skipped
  // when its pin is an id input since nothing analog sits there then
  function automatic logic [2:0] next_channel(input logic [2:0] c, input logic id_mode);
    logic [2:0] n;
    n = c + 3'h1;
    if (id_mode && n == CHAN_LAST_VOLT) begin
      n = CHAN_FIRST_TEMP;
    end
    return n;
  endfunction

  // Full six-bit id code as seen by software
  function automatic logic [5:0] id_code(input logic [5:0] lv, input logic id_mode);
    return {lv[5] & id_mode, lv[4:0]};
  endfunction

  // ****************************************************************
  // State
  // ****************************************************************
  state_type st_ff; // All registered state
  state_type nxt_st; // Next value
  logic conv_tick; // One cycle per conversion slot
  logic win_tick; // One cycle per id window
  logic [9:0] avg_result; // Averaged or single conversion result
  logic [4:0] avg_target; // Conversions per update
  logic status_bit0; // Shared status bit
  logic [5:0] id_now; // Current synchronised id code
  logic [1:0] temp_idx; // Temperature slot of the current channel

  assign conv_tick = (st_ff.tick_cnt == 17'(CONV_TICKS - 1));
  assign win_tick = (st_ff.win_cnt == 11'(ID_TICKS - 1));
  assign id_now = id_code(st_ff.sync_b, st_ff.id_ctrl[1]);
  assign avg_target = st_ff.avg_off_snap ? 5'h01 : 5'(AVG_SAMPLES);
  assign temp_idx = 2'(st_ff.chan - CHAN_FIRST_TEMP);
  // Sum of sixteen samples, temperatures sign-extended; bits 13:4 floor the mean for both signs
  assign avg_result = st_ff.avg_off_snap ? st_ff.acc[9:0] : st_ff.acc[13:4];
  // Shared bit follows the pin function
  assign status_bit0 = st_ff.id_ctrl[1] ? st_ff.change_flag : i_supply12_out_of_limit;

  // ****************************************************************
  // Next-state logic
  // ****************************************************************

  // Everything the block does in one cycle, frozen while the enable is low
  always_comb begin
    nxt_st = st_ff;
    nxt_st.conv_start = 1'b0;
    nxt_st.rvalid = 1'b0;
    if (i_clk_en) begin
      // Two flops before anything looks at the pins
      nxt_st.sync_a = {i_shared_pin_level, i_voltage_id_pins};
      nxt_st.sync_b = st_ff.sync_a;

      // Id change window: any difference from the window's snapshot counts
      nxt_st.win_cnt = win_tick ? 11'h000 : st_ff.win_cnt + 11'h001;
      if (id_now != st_ff.id_snap) begin
        nxt_st.change_seen = 1'b1;
      end
      if (win_tick) begin
        // Flag covers the window just ended; it clears itself when quiet
        nxt_st.change_flag = st_ff.id_ctrl[1] & (st_ff.change_seen | (id_now != st_ff.id_snap));
        nxt_st.change_seen = 1'b0;
        nxt_st.id_snap = id_now;
      end

      // Register writes; read-only and unmapped addresses ignore them
      if (i_reg_wr) begin
        unique case (i_reg_addr)
          ADDR_VOLTAGE_ID_CODE: begin
            nxt_st.id_ctrl = {i_reg_wdata[VID_PIN_SELECT_BIT], i_reg_wdata[VID_THRESHOLD_BIT]};
          end
          ADDR_FAN1_MINIMUM_HIGH_BYTE: begin
            nxt_st.fan1_min_high = i_reg_wdata;
          end
          ADDR_CONFIGURATION_TWO: begin
            nxt_st.cfg_two = i_reg_wdata;
          end
          ADDR_INT_MASK_TWO: begin
            nxt_st.mask_two = i_reg_wdata;
          end
          default: begin
          end
        endcase
      end

      // Register reads answer one cycle later from a flop
      if (i_reg_rd) begin
        nxt_st.rvalid = 1'b1;
        unique case (i_reg_addr)
          ADDR_REMOTE_ONE_TEMP: begin
            nxt_st.rdata = st_ff.temp_value[0];
          end
          ADDR_LOCAL_TEMPERATURE_READING: begin
            nxt_st.rdata = st_ff.temp_value[1];
          end
          ADDR_REMOTE_TWO_TEMP: begin
            nxt_st.rdata = st_ff.temp_value[2];
          end
          ADDR_STATUS_TWO: begin
            nxt_st.rdata = {7'h00, status_bit0};
          end
          ADDR_VOLTAGE_ID_CODE: begin
            nxt_st.rdata = {st_ff.id_ctrl, id_code(st_ff.sync_b, st_ff.id_ctrl[1])};
          end
          ADDR_FAN1_MINIMUM_HIGH_BYTE: begin
            nxt_st.rdata = st_ff.fan1_min_high;
          end
          ADDR_CONFIGURATION_TWO: begin
            nxt_st.rdata = st_ff.cfg_two;
          end
          ADDR_INT_MASK_TWO: begin
            nxt_st.rdata = st_ff.mask_two;
          end
          ADDR_EXT_RESOLUTION_TWO: begin
            nxt_st.rdata = st_ff.ext_res;
            // Hold every temperature until each high byte has been read
            nxt_st.freeze = 1'b1;
            nxt_st.read_seen = 3'h0;
          end
          default: begin
            if (i_reg_addr >= ADDR_VOLT_BASE && i_reg_addr < ADDR_REMOTE_ONE_TEMP) begin
              nxt_st.rdata = st_ff.volt_value[3'(i_reg_addr - ADDR_VOLT_BASE)];
            end else begin
              nxt_st.rdata = 8'h00; // Unmapped reads return zero
            end
          end
        endcase
        // Track which high bytes have been read while frozen
        if (st_ff.freeze && i_reg_addr >= ADDR_REMOTE_ONE_TEMP && i_reg_addr <= ADDR_REMOTE_TWO_TEMP) begin
          nxt_st.read_seen[2'(i_reg_addr - ADDR_REMOTE_ONE_TEMP)] = 1'b1;
          if ((st_ff.read_seen | (3'h1 << 2'(i_reg_addr - ADDR_REMOTE_ONE_TEMP))) == 3'h7) begin
            nxt_st.freeze = 1'b0;
          end
        end
      end

      // Conversion slot timer runs free so slots stay evenly spaced
      nxt_st.tick_cnt = conv_tick ? 17'h00000 : st_ff.tick_cnt + 17'h00001;

      // Converter sequencer
      unique case (st_ff.seq)
        SEQ_IDLE: begin
          if (conv_tick) begin
            nxt_st.conv_start = 1'b1;
            nxt_st.seq = SEQ_BUSY;
            // Settings are taken here: bypass for every conversion, averaging and channel only when a new result starts
            nxt_st.bypass = st_ff.cfg_two[CFG_BYPASS_BIT];
            if (st_ff.avg_cnt == 5'h00) begin
              nxt_st.avg_off_snap = st_ff.cfg_two[CFG_AVG_OFF_BIT];
              if (st_ff.cfg_two[CFG_SINGLE_BIT]) begin
                nxt_st.chan = st_ff.fan1_min_high[CHAN_SEL_LSB +: 3];
              end
            end
          end
        end
        SEQ_BUSY: begin
          if (i_conv_done) begin
            nxt_st.seq = SEQ_IDLE;
            // Temperatures are signed, voltages are not
            nxt_st.acc = st_ff.acc + (st_ff.chan >= CHAN_FIRST_TEMP ?
                         {{5{i_conv_value[9]}}, i_conv_value} : {5'h00, i_conv_value});
            nxt_st.avg_cnt = st_ff.avg_cnt + 5'h01;
          end
        end
      endcase

      // Store a finished result; remote and local share the averaging
      if (st_ff.seq == SEQ_IDLE && st_ff.avg_cnt == avg_target) begin
        if (st_ff.chan >= CHAN_FIRST_TEMP) begin
          // A frozen set drops this result; the next one arrives avg_target slots later
          if (!st_ff.freeze) begin
            nxt_st.temp_value[temp_idx] = avg_result[9:2];
            nxt_st.ext_res[EXT_REMOTE_ONE_LSB + 2 * temp_idx +: 2] = avg_result[1:0];
          end
        end else if (st_ff.chan <= CHAN_LAST_VOLT) begin
          nxt_st.volt_value[st_ff.chan] = avg_result[9:2];
        end
        nxt_st.acc = 15'h0000;
        nxt_st.avg_cnt = 5'h00;
        if (!st_ff.cfg_two[CFG_SINGLE_BIT]) begin
          nxt_st.chan = next_channel(st_ff.chan, st_ff.id_ctrl[1]);
        end
      end
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************

  // Asynchronous reset to fixed constants only
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      st_ff <= '0;
      st_ff.fan1_min_high <= RST_FAN1_HIGH;
      st_ff.cfg_two <= RST_CFG_TWO;
      st_ff.mask_two <= RST_MASK_TWO;
      st_ff.volt_value <= {5{RST_VOLT}};
      st_ff.temp_value <= {3{RST_TEMP}};
      st_ff.ext_res <= RST_EXT;
      st_ff.seq <= SEQ_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign o_reg_rdata = st_ff.rdata;
  assign o_reg_rvalid = st_ff.rvalid;
  assign o_conv_start = st_ff.conv_start;
  assign o_conv_channel = st_ff.chan;
  assign o_bypass_attenuators = st_ff.bypass;
  assign o_id_threshold_select = st_ff.id_ctrl[0];
  // Open-drain alert, low while an unmasked id change is flagged
  assign o_smbalert_n = ~(st_ff.id_ctrl[1] & st_ff.change_flag & ~st_ff.mask_two[MASK_ID_CHANGE_BIT]);

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  AST_ID_LOW_BITS: assert property (
    (i_clk_en && i_reg_rd && i_reg_addr == ADDR_VOLTAGE_ID_CODE) |=>
      o_reg_rvalid && o_reg_rdata[4:0] == $past(st_ff.sync_b[4:0]))
    else $error("Id register low bits do not match synchronised pins");

  AST_ID_BIT5_ZERO: assert property (
    (i_clk_en && i_reg_rd && i_reg_addr == ADDR_VOLTAGE_ID_CODE && !st_ff.id_ctrl[1]) |=>
      o_reg_rdata[5] == 1'b0)
    else $error("Id bit five not zero in supply mode");

  AST_THRESHOLD_OUT: assert property (
    (i_clk_en && i_reg_wr && i_reg_addr == ADDR_VOLTAGE_ID_CODE) |=>
      o_id_threshold_select == $past(i_reg_wdata[VID_THRESHOLD_BIT]))
    else $error("Threshold select did not follow the write");

  AST_STATUS_SUPPLY: assert property (
    (i_clk_en && i_reg_rd && i_reg_addr == ADDR_STATUS_TWO && !st_ff.id_ctrl[1]) |=>
      o_reg_rdata[0] == $past(i_supply12_out_of_limit))
    else $error("Status bit zero not showing supply limit");

  // A difference seen during a window must show in the flag once it closes
  AST_CHANGE_FLAGGED: assert property (
    (i_clk_en && win_tick && st_ff.id_ctrl[1] && st_ff.change_seen) |=> st_ff.change_flag)
    else $error("Id change not flagged at the end of its window");

  // Helper: cycles a seen difference has been pending; a stuck window timer
  // would let a change go unreported for ever, so the age is bounded
  logic [11:0] seen_age_ff; // Pending age of a seen difference

  // Clears one cycle after the window hands the difference to the flag
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      seen_age_ff <= 12'h000;
    end else if (i_clk_en) begin
      seen_age_ff <= st_ff.change_seen ? seen_age_ff + 12'h001 : 12'h000;
    end
  end

  AST_CHANGE_WINDOW: assert property (
    seen_age_ff < 12'(ID_TICKS))
    else $error("Id change pending for longer than one window");

  AST_ALERT_MASK: assert property (
    !o_smbalert_n |-> (st_ff.change_flag && st_ff.id_ctrl[1] && !st_ff.mask_two[MASK_ID_CHANGE_BIT]))
    else $error("Alert asserted while masked or without a change");

  AST_SINGLE_CHAN: assert property (
    (i_clk_en && st_ff.seq == SEQ_IDLE && conv_tick && st_ff.avg_cnt == 5'h00 && st_ff.cfg_two[CFG_SINGLE_BIT])
      |=> o_conv_start && o_conv_channel == $past(st_ff.fan1_min_high[7:5]))
    else $error("Single-channel start used the wrong channel");

  AST_FREEZE_HOLDS: assert property (
    st_ff.freeze |=> $stable(st_ff.temp_value) && $stable(st_ff.ext_res))
    else $error("Temperature changed while frozen");

  AST_BYPASS_NEXT: assert property (
    (i_clk_en && st_ff.seq == SEQ_IDLE && conv_tick) |=>
      o_bypass_attenuators == $past(st_ff.cfg_two[CFG_BYPASS_BIT]))
    else $error("Bypass not taken at conversion start");

  // Main scenarios the bench should reach
  COV_CHANGE: cover property ($rose(st_ff.change_flag));
  COV_MASKED_CHANGE: cover property (st_ff.change_flag && st_ff.id_ctrl[1] && st_ff.mask_two[MASK_ID_CHANGE_BIT]);
  COV_ALERT: cover property ($fell(o_smbalert_n));
  COV_FREEZE_RELEASE: cover property ($fell(st_ff.freeze));
  COV_SINGLE: cover property (o_conv_start && st_ff.cfg_two[CFG_SINGLE_BIT]);

endmodule

// ---- common/vid_adc_pkg.sv ----
package vid_adc_pkg;

  // ****************************************************************
  // Register offsets on the command-code port
  // ****************************************************************
  localparam logic [7:0] ADDR_VOLT_BASE = 8'h20; // Five voltage readings 0x20..0x24
  localparam logic [7:0] ADDR_REMOTE_ONE_TEMP = 8'h25;
  localparam logic [7:0] ADDR_LOCAL_TEMPERATURE_READING = 8'h26;
  localparam logic [7:0] ADDR_REMOTE_TWO_TEMP = 8'h27;
  localparam logic [7:0] ADDR_STATUS_TWO = 8'h42;
  localparam logic [7:0] ADDR_VOLTAGE_ID_CODE = 8'h43;
  localparam logic [7:0] ADDR_FAN1_MINIMUM_HIGH_BYTE = 8'h55;
  localparam logic [7:0] ADDR_CONFIGURATION_TWO = 8'h73;
  localparam logic [7:0] ADDR_INT_MASK_TWO = 8'h75;
  localparam logic [7:0] ADDR_EXT_RESOLUTION_TWO = 8'h77;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int VID_THRESHOLD_BIT = 6;   // Id threshold select in 0x43
  localparam int VID_PIN_SELECT_BIT = 7;  // Pin function select in 0x43
  localparam int CFG_AVG_OFF_BIT = 4;     // Averaging off in 0x73
  localparam int CFG_BYPASS_BIT = 5;      // Attenuator bypass in 0x73
  localparam int CFG_SINGLE_BIT = 6;      // Single-channel mode in 0x73
  localparam int MASK_ID_CHANGE_BIT = 0;  // Id change alert mask in 0x75
  localparam int CHAN_SEL_LSB = 5;        // Channel select 7:5 in 0x55
  localparam int EXT_REMOTE_ONE_LSB = 2;  // Low bits of remote 1 at 3:2

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] RST_VOLT = 8'h00;
  localparam logic [7:0] RST_TEMP = 8'h80;
  localparam logic [7:0] RST_EXT = 8'h00;
  localparam logic [7:0] RST_FAN1_HIGH = 8'hff;
  localparam logic [7:0] RST_CFG_TWO = 8'h00;
  localparam logic [7:0] RST_MASK_TWO = 8'h00;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int CONV_PERIOD_NS = 711000;    // One conversion slot, 711 us
  localparam int CONV_CYCLES = CONV_PERIOD_NS / CLK_PERIOD_NS;
  localparam int ID_WINDOW_NS = 11000;       // Id change window, 11 us
  localparam int ID_WINDOW_CYCLES = ID_WINDOW_NS / CLK_PERIOD_NS;
  localparam int AVG_SAMPLES = 16;           // Conversions per averaged result
  localparam logic [2:0] CHAN_LAST_VOLT = 3'h4; // 12 V input
  localparam logic [2:0] CHAN_FIRST_TEMP = 3'h5; // Remote 1

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic {
    SEQ_IDLE = 1'b0,
    SEQ_BUSY = 1'b1
  } seq_state_type;

  typedef struct packed {
    logic [5:0] sync_a;          // First synchroniser stage
    logic [5:0] sync_b;          // Second synchroniser stage
    logic [5:0] id_snap;         // Levels at the start of the window
    logic change_seen;           // A difference was seen this window
    logic change_flag;           // Id code change status
    logic [10:0] win_cnt;        // Window timer
    logic [1:0] id_ctrl;         // {pin_function_select, id_threshold_select}
    logic [7:0] fan1_min_high;
    logic [7:0] cfg_two;
    logic [7:0] mask_two;
    logic [4:0][7:0] volt_value;
    logic [2:0][7:0] temp_value; // Remote 1, local, remote 2
    logic [7:0] ext_res;
    logic freeze;
    logic [2:0] read_seen;
    seq_state_type seq;
    logic [16:0] tick_cnt;
    logic [2:0] chan;
    logic [4:0] avg_cnt;
    logic avg_off_snap;
    logic [14:0] acc;
    logic conv_start;
    logic bypass;
    logic [7:0] rdata;
    logic rvalid;
  } state_type;

endpackage

// ---- verification/conv_model.sv ----
`timescale 1ns/10ps
// ********
// Converter stand-in
// ********
module conv_model (
  input wire logic i_clk,
  input wire logic i_start,
  input wire logic [9:0] i_base, // Result the bench asks for
  input wire logic i_wobble, // Alternate base and base+1
  output logic o_done,
  output logic [9:0] o_value
);
  int wait_cnt = -1; // Cycles before answering, -1 when idle
  logic slow = 1'b0; // Alternates prompt and slow answers
  logic odd = 1'b0; // Phase of the wobble

  initial begin
    o_done = 1'b0;
    o_value = 10'h155;
  end

  // One result per start; the value line is scrambled outside the strobe
  // so a design that samples it late sees garbage, not the last result
  always @(posedge i_clk) begin
    o_done <= 1'b0;
    o_value <= ~o_value;
    if (i_start) begin
      wait_cnt <= slow ? 6 : 1;
      slow <= ~slow;
    end else if (wait_cnt == 0) begin
      o_done <= 1'b1;
      o_value <= i_base + {9'h000, i_wobble & odd};
      odd <= ~odd;
      wait_cnt <= -1;
    end else if (wait_cnt > 0) begin
      wait_cnt <= wait_cnt - 1;
    end
  end
endmodule

// ---- verification/test_voltage_id_monitor_adc_config.sv ----
`timescale 1ns/10ps
module test_voltage_id_monitor_adc_config;
  import vid_adc_pkg::*;
  logic i_clk_sys = 1'b0;
  logic i_rst = 1'b1;
  logic clk_en = 1'b1; // Clock enable held on
  logic [4:0] vid = 5'h00; // Dedicated id pins
  logic shared_lvl = 1'b0; // Shared supply/id pin level
  logic lim12 = 1'b0; // Supply limit result
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic rvalid;
  logic done;
  logic [9:0] value;
  logic start;
  logic [2:0] chan;
  logic bypass;
  logic id_threshold_select;
  logic alert_n;
  logic [9:0] base = 10'h000; // Converter result to hand back
  logic wobble = 1'b0;
  logic [7:0] got; // Last read data
  logic [7:0] old_hi;
  logic [31:0] seed = 32'd16283;
  logic [7:0] rst_addr [8] = '{8'h77, 8'h26, 8'h25, 8'h27, 8'h55, 8'h73, 8'h75, 8'h3f};
  logic [7:0] rst_val [8] = '{8'h00, 8'h80, 8'h80, 8'h80, 8'hff, 8'h00, 8'h00, 8'h00};
  int err_count = 0;
  int n_tests = 0;
  int i;
  int k;

  // Short conversion slot keeps the run brief; id window stays at 11 us
  vid_adc_monitor #(.CONV_TICKS(20), .ID_TICKS(1100)) uut (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_clk_en(clk_en), .i_voltage_id_pins(vid),
    .i_shared_pin_level(shared_lvl), .i_supply12_out_of_limit(lim12), .i_reg_wr(wr),
    .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
    .o_reg_rvalid(rvalid), .i_conv_done(done), .i_conv_value(value), .o_conv_start(start),
    .o_conv_channel(chan), .o_bypass_attenuators(bypass), .o_id_threshold_select(id_threshold_select),
    .o_smbalert_n(alert_n)
  );
  conv_model partner (
    .i_clk(i_clk_sys), .i_start(start), .i_base(base), .i_wobble(wobble),
    .o_done(done), .o_value(value)
  );

  always #5 i_clk_sys = ~i_clk_sys;

  // ********
  // Helpers
  // ********
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    n_tests++;
    if (seen !== want) begin
      err_count++;
      $display("wrong value t=%0t seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clk_sys);
    wr = 1'b1;
    addr = a;
    wdata = d;
    @(negedge i_clk_sys);
    wr = 1'b0;
  endtask

  // A missing answer leaves unknown data, which no compare accepts
  task automatic reg_rd(input logic [7:0] a);
    int n;
    @(negedge i_clk_sys);
    rd = 1'b1;
    addr = a;
    @(negedge i_clk_sys);
    rd = 1'b0;
    for (n = 0; n < 4 && rvalid !== 1'b1; n++) @(negedge i_clk_sys);
    got = (rvalid === 1'b1) ? rdata : 8'hxx;
  endtask

  task automatic wait_start(input logic [2:0] ch);
    int n;
    for (n = 0; n < 3000 && !(start === 1'b1 && chan === ch); n++) @(negedge i_clk_sys);
    check({7'h00, start}, 8'h01);
    repeat (12) @(negedge i_clk_sys);
  endtask

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Watchdog, well beyond the expected run of about 10k cycles
  initial begin
    repeat (60000) @(posedge i_clk_sys);
    err_count++;
    test_done();
  end

  // ********
  // Main sequence
  // ********
  initial begin
    repeat (16) @(negedge i_clk_sys);
    i_rst = 1'b0;
    // Reset values, including an unmapped offset; the extended byte goes first
    // and all three high bytes follow, so the freeze it starts is let go again
    for (i = 0; i < 8; i++) begin
      reg_rd(rst_addr[i]);
      check(got, rst_val[i]);
    end
    // Id capture under both pin functions, random levels
    for (i = 0; i < 8; i++) begin
      seed = xs(seed);
      vid = seed[4:0];
      shared_lvl = seed[5];
      lim12 = seed[8];
      reg_wr(ADDR_VOLTAGE_ID_CODE, {i[0], seed[6], 6'h00});
      repeat (3) @(negedge i_clk_sys);
      reg_rd(ADDR_VOLTAGE_ID_CODE);
      check(got, {i[0], seed[6], seed[5] & i[0], seed[4:0]});
      check({7'h00, id_threshold_select}, {7'h00, seed[6]});
      reg_rd(ADDR_STATUS_TWO);
      if (!i[0]) check({7'h00, got[0]}, {7'h00, seed[8]});
    end
    // Change detection, alert unmasked then masked
    reg_wr(ADDR_VOLTAGE_ID_CODE, 8'h80);
    for (i = 0; i < 2; i++) begin
      reg_wr(ADDR_INT_MASK_TWO, {7'h00, i[0]});
      repeat (2500) @(negedge i_clk_sys);
      reg_rd(ADDR_STATUS_TWO);
      check({7'h00, got[0]}, 8'h00);
      vid = ~vid;
      for (k = 0; k < 1000 && got[0] !== 1'b1; k++) reg_rd(ADDR_STATUS_TWO);
      check({7'h00, got[0]}, 8'h01);
      check({7'h00, alert_n}, {7'h00, i[0]});
    end
    // Single-channel voltages, averaging off; the wait lets old work drain
    reg_wr(ADDR_VOLTAGE_ID_CODE, 8'h00);
    reg_wr(ADDR_CONFIGURATION_TWO, 8'h50);
    repeat (1000) @(negedge i_clk_sys);
    for (i = 0; i < 5; i++) begin
      seed = xs(seed);
      base = seed[9:0];
      reg_wr(ADDR_FAN1_MINIMUM_HIGH_BYTE, {i[2:0], 5'h1f});
      wait_start(i[2:0]);
      reg_rd(ADDR_VOLT_BASE + i[7:0]);
      check(got, base[9:2]);
    end
    // Local temperature; the most negative code comes second so that it
    // replaces a random result rather than the matching reset value
    reg_wr(ADDR_CONFIGURATION_TWO, 8'h70);
    reg_wr(ADDR_FAN1_MINIMUM_HIGH_BYTE, 8'hc0);
    for (i = 0; i < 3; i++) begin
      seed = xs(seed);
      base = (i == 1) ? 10'h200 : seed[9:0];
      wait_start(3'h6);
      check({7'h00, bypass}, 8'h01);
      reg_rd(ADDR_EXT_RESOLUTION_TWO);
      check({6'h00, got[5:4]}, {6'h00, base[1:0]});
      reg_rd(ADDR_REMOTE_ONE_TEMP);
      reg_rd(ADDR_REMOTE_TWO_TEMP);
      reg_rd(ADDR_LOCAL_TEMPERATURE_READING);
      check(got, base[9:2]);
    end
    // Freeze holds the old byte until all three bytes are read
    old_hi = base[9:2];
    reg_rd(ADDR_EXT_RESOLUTION_TWO);
    base = {~old_hi, 2'b01};
    wait_start(3'h6);
    reg_rd(ADDR_LOCAL_TEMPERATURE_READING);
    check(got, old_hi);
    reg_rd(ADDR_REMOTE_ONE_TEMP);
    reg_rd(ADDR_REMOTE_TWO_TEMP);
    wait_start(3'h6);
    reg_rd(ADDR_LOCAL_TEMPERATURE_READING);
    check(got, ~old_hi);
    // Averaging on: base and base+1 alternate, floor keeps base
    reg_wr(ADDR_CONFIGURATION_TWO, 8'h40);
    seed = xs(seed);
    base = {1'b0, seed[8:1], 1'b0};
    wobble = 1'b1;
    repeat (1200) @(negedge i_clk_sys);
    reg_rd(ADDR_EXT_RESOLUTION_TWO);
    check({6'h00, got[5:4]}, 8'h00);
    reg_rd(ADDR_LOCAL_TEMPERATURE_READING);
    check(got, base[9:2]);
    test_done();
  end
endmodule
